// *** logic/dac_card_defines.svh ***
// Purpose: constants of the output card control block
// Assumes: one 40 MHz clock, synchronous reset
// Notes:   operation codes are local encodings
`ifndef DAC_CARD_DEFINES_SVH
`define DAC_CARD_DEFINES_SVH

`define BUS_W          16
`define DAC_W          12
`define DAC_MSB        11
`define SUB_WRITE      2'h0
`define SUB_READ       2'h3
`define OP_OUTPUT      3'h1
`define OP_WRITE_ONLY  3'h2
`define OP_CYCLE       3'h3
`define OP_SYS_DISABLE 3'h4
`define OP_SYS_ENABLE  3'h5
`define OP_READ_VALUE  3'h6
`define LSR_GAP_CYC    4'h2
`define GAP_ONE        4'h1
`define GAP_ZERO       4'h0
`define WORD_ZERO      16'h0000
`define DAC_ZERO       12'h000

`endif

// *** logic/dac_card_pkg.sv ***
// Purpose: types of the output card control block
// Assumes: constants come from dac_card_defines.svh
// Notes:   none
package dac_card_pkg;

    typedef struct packed {
        logic       card_select;
        logic       read_not_write;
        logic       subaddr_bit1;
        logic       subaddr_bit0;
        logic       op_code_bit2;
        logic       op_code_bit1;
        logic       op_code_bit0;
    } ctrl_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DECODE,
        ST_FIRST_RANK_LOAD_STROBE,
        ST_GAP,
        ST_LSR
    } seq_state_t;

endpackage : dac_card_pkg

// *** logic/dac_output_card_control.sv ***
// Purpose: control logic of a backplane addressed converter output card
// Assumes: all inputs synchronous to clk; strobes are levels, edges matter
// Notes:   bus transceiver direction only, never floated
//          system enable restores only a card loaded at least once
//          strobe rises during a running sequence are captured, not decoded
//          gated converter word is the all-zero code
//          read enable ends on the next strobe rise of any kind
// Function
// - power-on clear resets control and first rank register first.
// - subaddress 00 selects write target, 11 selects read target.
// - capture select, direction, subaddress, code on each data strobe.
// - write: driver enable low, bus feeds first rank; read: high, drive.
// - transceivers always face one way, never high impedance.
// - write subaddress zero with code makes first rank strobe, loads 16 bits.
// - read-value returns first rank contents at any time.
// - only power-on clear clears first rank register.
// - mux takes external inputs when select low, else first rank 0-11.
// - each cycle latches multiplexer word into second rank.
// - second rank loads only in cycle; cycle follows all but write-only.
// - load-second-rank strobe follows first rank strobe, loads, starts cycle.
// - output gates block converter data until second rank programmed.
// - converter data forced zero while external or card enable low.
// - card enable rises on each second-rank strobe, falls on disable.
// - enables high again deliver held second rank word, no reload.
// - converter word is twelve bits from second rank.
// - invert bit eleven of second rank word toward converter.
// - read-value decodes subaddress three, asserts active-low return enable.
// - system-enable restores card enable, output returns if external high.
`timescale 1ns/1ps
`include "dac_card_defines.svh"

module dac_output_card_control (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                card_select,
    input  wire logic                read_not_write,
    input  wire logic                subaddr_bit0,
    input  wire logic                subaddr_bit1,
    input  wire logic                op_code_bit0,
    input  wire logic                op_code_bit1,
    input  wire logic                op_code_bit2,
    input  wire logic                control_capture_strobe,
    input  wire logic [`BUS_W-1:0]   bus_in,
    input  wire logic [`DAC_W-1:0]   ext_data,
    input  wire logic                external_data_select,
    input  wire logic                external_output_enable,
    output logic      [`BUS_W-1:0]   bus_out,
    output logic                     bus_driver_enable,
    output logic                     first_rank_return_enable_n,
    output logic                     first_rank_load_strobe,
    output logic                     second_rank_load_strobe,
    output logic                     card_output_enable,
    output logic      [`DAC_W-1:0]   dac_data
);

    // strobe edge detect and control capture
    logic                    dst_prev_q;
    logic                    dst_prev_d;
    dac_card_pkg::ctrl_t     ctrl_q;
    dac_card_pkg::ctrl_t     ctrl_d;
    logic [`BUS_W-1:0]       bus_cap_q;
    logic [`BUS_W-1:0]       bus_cap_d;
    logic                    dst_rise;

    // sequencer
    dac_card_pkg::seq_state_t state_q;
    dac_card_pkg::seq_state_t state_d;
    logic [3:0]              gap_q;
    logic [3:0]              gap_d;
    logic                    cycle_after_q;
    logic                    cycle_after_d;

    // storage and enables
    logic [`BUS_W-1:0]       first_rank_q;
    logic [`BUS_W-1:0]       first_rank_d;
    logic [`DAC_W-1:0]       second_rank_q;
    logic [`DAC_W-1:0]       second_rank_d;
    logic                    loaded_q;
    logic                    loaded_d;
    logic                    cen_q;
    logic                    cen_d;
    logic                    first_rank_load_strobe_q;
    logic                    first_rank_load_strobe_d;
    logic                    lsr_q;
    logic                    lsr_d;
    logic                    first_rank_load_strobe_prev_q;
    logic                    lsr_prev_q;
    logic                    read_q;
    logic                    read_d;
    logic [`BUS_W-1:0]       bus_out_d;
    logic [`DAC_W-1:0]       dac_d;
    logic [`DAC_W-1:0]       mux_word;
    logic [`DAC_W-1:0]       conv_word;
    logic                    gate_open;

    // next values of the port flops
    logic                    bde_d;
    logic                    ret_n_d;
    logic                    frs_d;
    logic                    srs_d;
    logic                    coe_d;

    logic [1:0]              sub;
    logic [2:0]              op;
    logic                    wr_sel;
    logic                    rd_sel;

    // edge flop resets low like the idle strobe: no false edge
    assign dst_rise = control_capture_strobe & ~dst_prev_q;
    assign sub      = {ctrl_q.subaddr_bit1, ctrl_q.subaddr_bit0};
    assign op       = {ctrl_q.op_code_bit2, ctrl_q.op_code_bit1,
                       ctrl_q.op_code_bit0};
    assign wr_sel   = ctrl_q.card_select & ~ctrl_q.read_not_write
                      & (sub == `SUB_WRITE);
    assign rd_sel   = ctrl_q.card_select & ctrl_q.read_not_write
                      & (sub == `SUB_READ);

    // capture on each data strobe
    always_comb begin
        dst_prev_d = control_capture_strobe;
        ctrl_d     = ctrl_q;
        bus_cap_d  = bus_cap_q;
        if (dst_rise) begin
            ctrl_d = '{card_select, read_not_write, subaddr_bit1,
                       subaddr_bit0, op_code_bit2, op_code_bit1,
                       op_code_bit0};
            // bus word taken on the same edge as the control lines
            bus_cap_d = bus_in;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dst_prev_q <= 1'b0;
            ctrl_q     <= '0;
            bus_cap_q  <= `WORD_ZERO;
        end else begin
            dst_prev_q <= dst_prev_d;
            ctrl_q     <= ctrl_d;
            bus_cap_q  <= bus_cap_d;
        end
    end

    // instruction decode and strobe sequence
    always_comb begin
        state_d       = state_q;
        gap_d         = gap_q;
        cycle_after_d = cycle_after_q;
        first_rank_load_strobe_d        = 1'b0;
        lsr_d         = 1'b0;
        read_d        = read_q;
        cen_d         = cen_q;
        if (dst_rise) begin
            read_d = 1'b0;
        end
        case (state_q)
            dac_card_pkg::ST_IDLE: begin
                if (dst_rise) begin
                    state_d = dac_card_pkg::ST_DECODE;
                end
            end
            dac_card_pkg::ST_DECODE: begin
                // only writes to subaddress zero or reads of three act
                state_d = dac_card_pkg::ST_IDLE;
                if (wr_sel && (op == `OP_OUTPUT ||
                               op == `OP_WRITE_ONLY)) begin
                    first_rank_load_strobe_d        = 1'b1;
                    cycle_after_d = (op == `OP_OUTPUT);
                    state_d       = dac_card_pkg::ST_FIRST_RANK_LOAD_STROBE;
                end else if (wr_sel && op == `OP_CYCLE) begin
                    lsr_d   = 1'b1;
                    state_d = dac_card_pkg::ST_LSR;
                end else if (wr_sel && op == `OP_SYS_DISABLE) begin
                    cen_d = 1'b0;
                end else if (wr_sel && op == `OP_SYS_ENABLE) begin
                    cen_d = loaded_q;
                end else if (rd_sel && op == `OP_READ_VALUE) begin
                    read_d = 1'b1;
                end
            end
            dac_card_pkg::ST_FIRST_RANK_LOAD_STROBE: begin
                if (cycle_after_q) begin
                    // second rank load waits a gap behind the first
                    gap_d   = `LSR_GAP_CYC;
                    state_d = dac_card_pkg::ST_GAP;
                end else begin
                    state_d = dac_card_pkg::ST_IDLE;
                end
            end
            dac_card_pkg::ST_GAP: begin
                // counter ends at one so the load follows the gap exactly
                if (gap_q <= `GAP_ONE) begin
                    gap_d   = `GAP_ZERO;
                    lsr_d   = 1'b1;
                    state_d = dac_card_pkg::ST_LSR;
                end else begin
                    gap_d = gap_q - `GAP_ONE;
                end
            end
            dac_card_pkg::ST_LSR: begin
                state_d = dac_card_pkg::ST_IDLE;
            end
            default: begin
                state_d = dac_card_pkg::ST_IDLE;
            end
        endcase
        // every second rank load also raises the card enable
        if (lsr_q && !lsr_prev_q) begin
            cen_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q       <= dac_card_pkg::ST_IDLE;
            gap_q         <= `GAP_ZERO;
            cycle_after_q <= 1'b0;
            first_rank_load_strobe_q        <= 1'b0;
            lsr_q         <= 1'b0;
            read_q        <= 1'b0;
            cen_q         <= 1'b0;
        end else begin
            state_q       <= state_d;
            gap_q         <= gap_d;
            cycle_after_q <= cycle_after_d;
            first_rank_load_strobe_q        <= first_rank_load_strobe_d;
            lsr_q         <= lsr_d;
            read_q        <= read_d;
            cen_q         <= cen_d;
        end
    end

    // storage ranks and output gates
    assign mux_word = external_data_select ? first_rank_q[`DAC_W-1:0]
                                           : ext_data;

    always_comb begin
        first_rank_d  = first_rank_q;
        second_rank_d = second_rank_q;
        loaded_d      = loaded_q;
        if (first_rank_load_strobe_q && !first_rank_load_strobe_prev_q) begin
            first_rank_d = bus_cap_q;
        end
        if (lsr_q && !lsr_prev_q) begin
            second_rank_d = mux_word;
            loaded_d      = 1'b1;
        end
        bus_out_d = first_rank_d;
        // msb flipped: two's complement into the converter's format
        conv_word = {~second_rank_q[`DAC_MSB],
                     second_rank_q[`DAC_MSB-1:0]};
        gate_open = loaded_q & cen_q & external_output_enable;
        if (gate_open) begin
            dac_d = conv_word;
        end else begin
            dac_d = `DAC_ZERO;
        end
        bde_d   = read_d;
        ret_n_d = ~read_d;
        frs_d   = first_rank_load_strobe_q;
        srs_d   = lsr_q;
        coe_d   = cen_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            first_rank_q  <= `WORD_ZERO;
            second_rank_q <= `DAC_ZERO;
            loaded_q      <= 1'b0;
            first_rank_load_strobe_prev_q   <= 1'b0;
            lsr_prev_q    <= 1'b0;
            bus_out       <= `WORD_ZERO;
            dac_data      <= `DAC_ZERO;
            bus_driver_enable          <= 1'b0;
            first_rank_return_enable_n <= 1'b1;
            first_rank_load_strobe     <= 1'b0;
            second_rank_load_strobe    <= 1'b0;
            card_output_enable         <= 1'b0;
        end else begin
            first_rank_q  <= first_rank_d;
            second_rank_q <= second_rank_d;
            loaded_q      <= loaded_d;
            first_rank_load_strobe_prev_q   <= first_rank_load_strobe_q;
            lsr_prev_q    <= lsr_q;
            bus_out       <= bus_out_d;
            dac_data      <= dac_d;
            // every port comes straight from one of these flops
            bus_driver_enable          <= bde_d;
            first_rank_return_enable_n <= ret_n_d;
            first_rank_load_strobe     <= frs_d;
            second_rank_load_strobe    <= srs_d;
            card_output_enable         <= coe_d;
        end
    end

endmodule : dac_output_card_control

// *** tb/dac_card_monitor.sv ***
// Purpose: port checker of the output card control block
// Assumes: one clock, synchronous active high reset
// Notes:   bound to the design top
`timescale 1ns/1ps
`include "dac_card_defines.svh"
module dac_card_monitor (
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              card_select,
    input wire logic              read_not_write,
    input wire logic              subaddr_bit0,
    input wire logic              subaddr_bit1,
    input wire logic              op_code_bit0,
    input wire logic              op_code_bit1,
    input wire logic              op_code_bit2,
    input wire logic              control_capture_strobe,
    input wire logic [`DAC_W-1:0] ext_data,
    input wire logic              external_data_select,
    input wire logic              external_output_enable,
    input wire logic [`BUS_W-1:0] bus_out,
    input wire logic              bus_driver_enable,
    input wire logic              first_rank_return_enable_n,
    input wire logic              first_rank_load_strobe,
    input wire logic              second_rank_load_strobe,
    input wire logic              card_output_enable,
    input wire logic [`DAC_W-1:0] dac_data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [2:0] op;
    logic       wr0;
    logic       rd3;
    assign op  = {op_code_bit2, op_code_bit1, op_code_bit0};
    assign wr0 = card_select && !read_not_write && !subaddr_bit1
                 && !subaddr_bit0;
    assign rd3 = card_select && read_not_write && subaddr_bit1
                 && subaddr_bit0;
    sequence take_s;
        $rose(control_capture_strobe);
    endsequence
    sequence load_s;
        second_rank_load_strobe ##1 external_output_enable [*2];
    endsequence
    reset_clear_a: assert property (disable iff (1'b0) rst |=>
        !card_output_enable && dac_data == `DAC_ZERO
        && bus_out == `WORD_ZERO) else $error("reset left state");
    dir_pair_a: assert property (first_rank_return_enable_n
        != bus_driver_enable) else $error("direction pair broken");
    gate_zero_a: assert property ((!card_output_enable
        |-> dac_data == `DAC_ZERO) and (!external_output_enable
        |=> dac_data == `DAC_ZERO)) else $error("gated word not zero");
    word_hold_a: assert property ((!second_rank_load_strobe
        && card_output_enable && external_output_enable) [*3]
        |-> $stable(dac_data)) else $error("word moved");
    rank_hold_a: assert property ($changed(bus_out)
        |-> first_rank_load_strobe) else $error("first rank moved");
    out_seq_a: assert property (take_s ##0 (wr0 && op == `OP_OUTPUT)
        |-> ##3 first_rank_load_strobe ##3 second_rank_load_strobe
        ##1 card_output_enable) else $error("output sequence wrong");
    wo_seq_a: assert property (take_s ##0 (wr0 && op == `OP_WRITE_ONLY)
        |-> ##3 first_rank_load_strobe ##1 !second_rank_load_strobe [*8])
        else $error("write only cycled");
    rd_seq_a: assert property (take_s ##0 (rd3 && op == `OP_READ_VALUE)
        |-> ##3 bus_driver_enable) else $error("read not driven");
    sd_seq_a: assert property (take_s ##0 (wr0 && op == `OP_SYS_DISABLE)
        |-> ##4 !card_output_enable ##1 dac_data == `DAC_ZERO)
        else $error("disable ignored");
    ignore_a: assert property (take_s ##0 !card_select |=>
        (!first_rank_load_strobe && !second_rank_load_strobe) [*8])
        else $error("unselected card acted");
    mux_path_a: assert property (load_s |-> dac_data ==
        (($past(external_data_select, 2) ? $past(bus_out[11:0], 2)
        : $past(ext_data, 2)) ^ 12'h800)) else $error("word path wrong");
endmodule : dac_card_monitor

bind dac_output_card_control dac_card_monitor u_mon (.clk(clk),
    .rst(rst), .card_select(card_select), .ext_data(ext_data),
    .read_not_write(read_not_write), .subaddr_bit0(subaddr_bit0),
    .subaddr_bit1(subaddr_bit1), .op_code_bit0(op_code_bit0),
    .op_code_bit1(op_code_bit1), .op_code_bit2(op_code_bit2),
    .control_capture_strobe(control_capture_strobe),
    .external_data_select(external_data_select),
    .external_output_enable(external_output_enable), .bus_out(bus_out),
    .bus_driver_enable(bus_driver_enable), .dac_data(dac_data),
    .first_rank_return_enable_n(first_rank_return_enable_n),
    .first_rank_load_strobe(first_rank_load_strobe),
    .second_rank_load_strobe(second_rank_load_strobe),
    .card_output_enable(card_output_enable));

// *** tb/backplane_host_model.sv ***
// Purpose: backplane controller issuing card instructions
// Assumes: drives at the falling edge of clk
// Notes:   released lines carry scrambled values
`timescale 1ns/1ps
`include "dac_card_defines.svh"
module backplane_host_model (
    input  wire logic                clk,
    input  wire logic                bus_driver_enable,
    output dac_card_pkg::ctrl_t      ctrl,
    output logic                     strobe,
    output logic      [`BUS_W-1:0]   bus_in
);
    initial begin
        ctrl = '0;
        strobe = 1'b0;
        bus_in = `WORD_ZERO;
    end
    task automatic send(input dac_card_pkg::ctrl_t c,
                        input logic [`BUS_W-1:0] w, input int slow);
        @(negedge clk);
        ctrl = c;
        bus_in = w;
        repeat (slow) @(negedge clk);
        strobe = 1'b1;
        repeat (3) @(negedge clk);
        strobe = 1'b0;
        ctrl = dac_card_pkg::ctrl_t'(~c);
        bus_in = ~w;
        repeat (10) begin
            @(negedge clk);
            if (bus_driver_enable) bus_in = ~bus_in;
        end
    endtask : send
endmodule : backplane_host_model

// *** tb/tb_top.sv ***
// Purpose: self-checking bench of the output card control block
// Assumes: inputs change at the falling edge
// Notes:   expected state kept by a small reference model
`timescale 1ns/1ps
`include "dac_card_defines.svh"
module tb_top;
    logic                clk = 1'b0;
    logic                rst = 1'b1;
    dac_card_pkg::ctrl_t ctrl;
    logic                strobe;
    logic [15:0]         bus_in, bus_out, fr_m;
    logic [11:0]         ext_data, dac_data, sr_m;
    logic                external_data_select, external_output_enable;
    logic                bus_driver_enable, first_rank_return_enable_n;
    logic                cen_m, ld_m, rd_m, card_output_enable;
    int                  num_errors = 0;
    int                  checks = 0;
    wire [15:0] seen_st = {bus_driver_enable, first_rank_return_enable_n,
                           card_output_enable, 1'b0, dac_data};
    always #12.5 clk = ~clk;
    backplane_host_model u_host (.clk(clk), .ctrl(ctrl), .strobe(strobe),
        .bus_driver_enable(bus_driver_enable), .bus_in(bus_in));
    dac_output_card_control u_dac_output_card_control (.clk(clk),
        .rst(rst), .card_select(ctrl.card_select),
        .read_not_write(ctrl.read_not_write), .subaddr_bit0(ctrl.subaddr_bit0),
        .subaddr_bit1(ctrl.subaddr_bit1), .op_code_bit0(ctrl.op_code_bit0),
        .op_code_bit1(ctrl.op_code_bit1), .op_code_bit2(ctrl.op_code_bit2),
        .control_capture_strobe(strobe), .bus_in(bus_in),
        .ext_data(ext_data), .external_data_select(external_data_select),
        .external_output_enable(external_output_enable), .bus_out(bus_out),
        .bus_driver_enable(bus_driver_enable), .dac_data(dac_data),
        .first_rank_return_enable_n(first_rank_return_enable_n),
        .first_rank_load_strobe(), .second_rank_load_strobe(),
        .card_output_enable(card_output_enable));
    function automatic logic [15:0] exp_st(logic rd, logic c, logic e,
                                           logic [11:0] s);
        return {rd, ~rd, c, 1'b0, (c && e) ? s ^ 12'h800 : `DAC_ZERO};
    endfunction : exp_st
    task automatic chk(input string what, input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic look(input string what);
        chk({what, " status"}, seen_st,
            exp_st(rd_m, cen_m, external_output_enable, sr_m));
        chk({what, " first rank"}, bus_out, fr_m);
    endtask : look
    task automatic op(input logic sel, rnw, input logic [1:0] sub,
                      input logic [2:0] code, input logic [15:0] w);
        u_host.send(dac_card_pkg::ctrl_t'({sel, rnw, sub, code}), w,
                    $urandom_range(2, 0));
        if (sel && !rnw && sub == `SUB_WRITE) begin
            if (code == `OP_OUTPUT || code == `OP_WRITE_ONLY) fr_m = w;
            if (code == `OP_OUTPUT || code == `OP_CYCLE) begin
                sr_m = external_data_select ? fr_m[11:0] : ext_data;
                ld_m = 1'b1;
                cen_m = 1'b1;
            end
            if (code == `OP_SYS_DISABLE) cen_m = 1'b0;
            if (code == `OP_SYS_ENABLE) cen_m = ld_m;
        end
        rd_m = sel && rnw && sub == `SUB_READ && code == `OP_READ_VALUE;
    endtask : op
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (4000) @(posedge clk);
        num_errors++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h3e2a9f80));
        {fr_m, sr_m, cen_m, ld_m, rd_m} = '0;
        ext_data = `DAC_ZERO;
        external_data_select = 1'b1;
        external_output_enable = 1'b1;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        look("reset");
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            external_data_select = i[0];
            ext_data = 12'($urandom);
            op(1'b1, 1'b0, `SUB_WRITE, `OP_OUTPUT,
               i == 0 ? 16'hffff : i == 1 ? 16'h0800 : 16'($urandom));
            look("output");
            op(1'b1, 1'b1, `SUB_READ, `OP_READ_VALUE, 16'($urandom));
            look("read");
        end
        $display("test output and read done");
        external_data_select = 1'b1;
        op(1'b1, 1'b0, `SUB_WRITE, `OP_WRITE_ONLY, 16'($urandom));
        look("write only");
        op(1'b1, 1'b0, `SUB_WRITE, `OP_CYCLE, 16'($urandom));
        look("cycle");
        $display("test write only done");
        for (int i = 0; i < 4; i++) begin
            op(i != 0, i == 2, i == 1 ? 2'h1 : `SUB_WRITE,
               i == 3 ? 3'h7 : `OP_OUTPUT, 16'($urandom));
            look("refused");
        end
        $display("test refusals done");
        op(1'b1, 1'b0, `SUB_WRITE, `OP_SYS_DISABLE, 16'($urandom));
        look("disable");
        op(1'b1, 1'b0, `SUB_WRITE, `OP_SYS_ENABLE, 16'($urandom));
        look("enable");
        external_output_enable = 1'b0;
        repeat (3) @(negedge clk);
        look("external off");
        external_output_enable = 1'b1;
        repeat (3) @(negedge clk);
        look("external on");
        $display("test enables done");
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        {fr_m, cen_m, ld_m} = '0;
        look("second reset");
        op(1'b1, 1'b0, `SUB_WRITE, `OP_SYS_ENABLE, 16'($urandom));
        look("enable unloaded");
        $display("test second reset done");
        stop_test();
    end
endmodule : tb_top
